/* File: hw/eqh_pkg.sv */
// Constants and types for the Ethernet queue halt, flow control and filer block
package eqh_pkg;
   localparam logic [7:0]  TX_RING_STATUS_ADDR = 8'h00;
   localparam logic [7:0]  TX_COAL_ADDR        = 8'h04;
   localparam logic [7:0]  RX_CTRL_ADDR        = 8'h08;
   localparam logic [7:0]  RX_COAL_ADDR        = 8'h0C;
   localparam logic [7:0]  RX_EXTRACT_ADDR     = 8'h10;
   localparam logic [7:0]  FILER_INDEX_ADDR    = 8'h14;
   localparam logic [7:0]  FILER_CTRL_ADDR     = 8'h18;
   localparam logic [7:0]  FILER_PROP_ADDR     = 8'h1C;
   localparam logic [7:0]  RING_SEL_ADDR       = 8'h20;
   localparam logic [7:0]  RING_PARAMS_ADDR    = 8'h24;
   localparam logic [7:0]  RING_LAST_FREE_ADDR = 8'h28;
   localparam logic [7:0]  RX_EXTRACTED_ADDR   = 8'h2C;
   localparam logic [7:0]  RX_RESULT_ADDR      = 8'h30;
   localparam logic [7:0]  TX_QUEUE_EN_ADDR    = 8'h34;
   localparam logic [31:0] REG_RESET           = 32'h0000_0000;
   localparam int          HALT_LSB            = 0;
   localparam int          FRAME_EVT_LSB       = 21;
   localparam int          COAL_SEL_BIT        = 1;
   localparam int          LFC_BIT             = 17;
   localparam int          FILER_EN_BIT        = 15;
   localparam int          SHORT_ACCEPT_BIT    = 4;
   localparam int          FIRST_EVT_RING      = 5;
   localparam int          RINGS               = 8;
   localparam int          FILER_DEPTH         = 16;
   localparam int          COAL_DIVIDE         = 64;
   localparam logic [5:0]  COAL_LAST           = 6'(COAL_DIVIDE - 1);
   localparam logic [15:0] TINY_FRAME_MAX      = 16'h0010;
   localparam logic [15:0] MIN_FRAME           = 16'h0040;
   localparam logic [15:0] MAC_CTRL_TYPE       = 16'h8808;
   localparam logic [15:0] IPV4_TYPE           = 16'h0800;
   localparam logic [15:0] L2_HDR_LEN          = 16'h000E;
   localparam logic [15:0] ETYPE_HI_POS        = 16'h000C;
   localparam logic [15:0] ETYPE_LO_POS        = 16'h000D;
   localparam logic [3:0]  LAST_RULE           = 4'hF;
   localparam int          RULE_REJECT_BIT     = 5;
   localparam int          RULE_CLUSTER_BIT    = 6;
   localparam int          RULE_CHAIN_BIT      = 7;
   localparam logic [3:0]  PROP_ETHERTYPE      = 4'h0;
   localparam logic [3:0]  PROP_EXTRACTED      = 4'h1;
   localparam logic [3:0]  PROP_LENGTH         = 4'h2;
   localparam logic [1:0]  EXTRACT_L2          = 2'h1;
   localparam logic [1:0]  EXTRACT_AFTER_L2    = 2'h2;
   localparam logic [1:0]  EXTRACT_AFTER_L3    = 2'h3;

   typedef enum logic [1:0] {
      SKIP_NONE           = 2'b00,
      SKIP_TO_UNCHAINED   = 2'b01,
      SKIP_TO_CLUSTER_END = 2'b10
   } eqh_skip_type;

   typedef enum logic [1:0] {
      FS_IDLE = 2'b00,
      FS_WALK = 2'b01
   } eqh_filer_state_type;
endpackage : eqh_pkg

/* File: hw/eqh_queue_ctrl.sv */
// Transmit ring halt, coalescing ticks, lossless flow control and receive filer
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps

module eqh_queue_ctrl (
   input  wire logic         core_clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [7:0]   addr_in,
   input  wire logic [31:0]  wr_data_in,
   input  wire logic         wr_en_in,
   input  wire logic         rd_en_in,
   output logic      [31:0]  rd_data_out,
   input  wire logic [2:0]   tx_dma_ring_in,
   input  wire logic         tx_bad_addr_in,
   input  wire logic         tx_read_uncorrectable_in,
   input  wire logic         tx_desc_ready_in,
   input  wire logic         tx_desc_len_zero_in,
   input  wire logic         tx_no_ready_desc_in,
   input  wire logic         tx_frame_sent_in,
   input  wire logic [2:0]   tx_frame_ring_in,
   output logic      [7:0]   tx_ring_dma_enable_out,
   input  wire logic         tx_interface_clock_in,
   input  wire logic         rx_interface_clock_in,
   output logic              tx_coalesce_tick_out,
   output logic              rx_coalesce_tick_out,
   input  wire logic [7:0]   rx_ring_active_in,
   input  wire logic [127:0] rx_hw_ptr_in,
   input  wire logic         link_full_duplex_in,
   input  wire logic         fifo_mode_in,
   output logic              pause_request_out,
   output logic              rx_flow_ctrl_output_out,
   input  wire logic         rx_valid_in,
   input  wire logic         rx_sof_in,
   input  wire logic         rx_eof_in,
   input  wire logic [7:0]   rx_data_in,
   output logic              rx_frame_done_out,
   output logic              rx_frame_accept_out
);
   import eqh_pkg::*;

   typedef struct packed {
      logic [7:0]            halt;
      logic [2:0]            frame_evt;
      logic [7:0]            queue_en;
      logic [7:0]            dma_en;
      logic [31:0]           transmit_coalesce_config;
      logic [31:0]           receive_control;
      logic [31:0]           receive_coalesce_config;
      logic [31:0]           receive_byte_extract_config;
      logic [3:0]            filer_idx;
      logic [2:0]            ring_sel;
      logic [7:0][15:0]      ring_len;
      logic [7:0][15:0]      ring_thr;
      logic [7:0][15:0]      last_free;
      logic [31:0]           rdata;
      logic                  tx_s1;
      logic                  tx_s2;
      logic                  tx_s3;
      logic                  rx_s1;
      logic                  rx_s2;
      logic                  rx_s3;
      logic [5:0]            tx_div;
      logic [5:0]            rx_div;
      logic                  tx_tick;
      logic                  rx_tick;
      logic [2:0]            scan;
      logic [7:0]            low;
      logic                  flow_req;
      logic                  pause;
      logic                  rx_flow_ctrl_output;
      logic [15:0]           count;
      logic [15:0]           etype;
      logic [15:0]           l3_end;
      logic [3:0][7:0]       extr;
      eqh_filer_state_type   fstate;
      eqh_skip_type          skip;
      logic                  in_cluster;
      logic [3:0]            rule;
      logic [15:0]           f_etype;
      logic [15:0]           f_len;
      logic [31:0]           f_extr;
      logic                  done;
      logic                  accept;
      logic [2:0]            result;
   } eqh_state_type;

   eqh_state_type q;
   eqh_state_type n;
   logic [7:0]    rule_ctrl_mem [FILER_DEPTH];
   logic [31:0]   rule_prop_mem [FILER_DEPTH];
   logic          gen_err;
   logic [7:0]    halt_set;

   function automatic logic eqh_extract_hit(input logic [7:0] cfg, input logic [15:0] pos,
                                            input logic [15:0] l3end);
      logic [15:0] base;
      base = 16'h0000;
      case (cfg[7:6])
         EXTRACT_L2:       base = 16'h0000;
         EXTRACT_AFTER_L2: base = L2_HDR_LEN;
         EXTRACT_AFTER_L3: base = l3end;
         default:          return 1'b0;
      endcase
      return pos == 16'(base + {10'h000, cfg[5:0]});
   endfunction : eqh_extract_hit

   function automatic logic [31:0] eqh_prop(input logic [3:0] sel, input logic [15:0] ety,
                                           input logic [15:0] len, input logic [31:0] ext);
      case (sel)
         PROP_ETHERTYPE: return {16'h0000, ety};
         PROP_EXTRACTED: return ext;
         PROP_LENGTH:    return {16'h0000, len};
         default:        return 32'h0000_0000;
      endcase
   endfunction : eqh_prop

   // Any of these stops the ring; a graceful stop is deliberately absent here
   assign gen_err  = tx_bad_addr_in | tx_read_uncorrectable_in
                   | (tx_desc_ready_in & tx_desc_len_zero_in);
   assign halt_set = (gen_err | tx_no_ready_desc_in) ? (8'h01 << tx_dma_ring_in) : 8'h00;

   always_comb begin
      logic [15:0] pos;
      logic [15:0] len;
      logic [15:0] rl;
      logic [15:0] lf;
      logic [15:0] hw;
      logic [15:0] free;
      logic [7:0]  c;
      logic [7:0]  evt_set;
      logic        hit;
      logic        decide;
      pos    = 16'h0000;
      len    = 16'h0000;
      rl     = 16'h0000;
      lf     = 16'h0000;
      hw     = 16'h0000;
      free   = 16'h0000;
      c      = 8'h00;
      hit    = 1'b0;
      decide = 1'b0;
      evt_set = 8'h00;
      n      = q;
      n.rdata = 32'h0000_0000;
      n.done  = 1'b0;

      // Set beats a simultaneous write-one clear
      if (tx_frame_sent_in && tx_frame_ring_in >= 3'(FIRST_EVT_RING)) begin
         evt_set = 8'h01 << 3'(tx_frame_ring_in - 3'(FIRST_EVT_RING));
      end
      if (wr_en_in && addr_in == TX_RING_STATUS_ADDR) begin
         n.halt      = q.halt & ~wr_data_in[HALT_LSB +: 8];
         n.frame_evt = q.frame_evt & ~wr_data_in[FRAME_EVT_LSB +: 3];
      end
      n.halt      = n.halt | halt_set;
      n.frame_evt = n.frame_evt | evt_set[2:0];
      n.dma_en    = q.queue_en & ~n.halt;

      if (wr_en_in) begin
         case (addr_in)
            TX_COAL_ADDR:        n.transmit_coalesce_config = wr_data_in;
            RX_CTRL_ADDR:        n.receive_control = wr_data_in;
            RX_COAL_ADDR:        n.receive_coalesce_config = wr_data_in;
            RX_EXTRACT_ADDR:     n.receive_byte_extract_config = wr_data_in;
            FILER_INDEX_ADDR:    n.filer_idx = wr_data_in[3:0];
            RING_SEL_ADDR:       n.ring_sel = wr_data_in[2:0];
            RING_PARAMS_ADDR: begin
               n.ring_len[q.ring_sel] = wr_data_in[15:0];
               n.ring_thr[q.ring_sel] = wr_data_in[31:16];
            end
            RING_LAST_FREE_ADDR: n.last_free[q.ring_sel] = wr_data_in[15:0];
            TX_QUEUE_EN_ADDR:    n.queue_en = wr_data_in[7:0];
            default:             n.rdata = 32'h0000_0000;
         endcase
      end
      if (rd_en_in) begin
         case (addr_in)
            TX_RING_STATUS_ADDR: n.rdata = ({29'h0, q.frame_evt} << FRAME_EVT_LSB)
                                         | {24'h0, q.halt};
            TX_COAL_ADDR:        n.rdata = q.transmit_coalesce_config;
            RX_CTRL_ADDR:        n.rdata = q.receive_control;
            RX_COAL_ADDR:        n.rdata = q.receive_coalesce_config;
            RX_EXTRACT_ADDR:     n.rdata = q.receive_byte_extract_config;
            FILER_INDEX_ADDR:    n.rdata = {28'h0, q.filer_idx};
            FILER_CTRL_ADDR:     n.rdata = {24'h0, rule_ctrl_mem[q.filer_idx]};
            FILER_PROP_ADDR:     n.rdata = rule_prop_mem[q.filer_idx];
            RING_SEL_ADDR:       n.rdata = {29'h0, q.ring_sel};
            RING_PARAMS_ADDR:    n.rdata = {q.ring_thr[q.ring_sel], q.ring_len[q.ring_sel]};
            RING_LAST_FREE_ADDR: n.rdata = {16'h0, q.last_free[q.ring_sel]};
            RX_EXTRACTED_ADDR:   n.rdata = q.f_extr;
            RX_RESULT_ADDR:      n.rdata = {27'h0, q.in_cluster, q.accept, q.result};
            TX_QUEUE_EN_ADDR:    n.rdata = {24'h0, q.queue_en};
            default:             n.rdata = 32'h0000_0000;
         endcase
      end

      // The second and third stages feed the edge detect
      n.tx_s1 = tx_interface_clock_in;
      n.tx_s2 = q.tx_s1;
      n.tx_s3 = q.tx_s2;
      n.rx_s1 = rx_interface_clock_in;
      n.rx_s2 = q.rx_s1;
      n.rx_s3 = q.rx_s2;
      n.tx_tick = 1'b0;
      n.rx_tick = 1'b0;
      if (q.transmit_coalesce_config[COAL_SEL_BIT] || (q.tx_s2 && !q.tx_s3)) begin
         n.tx_div  = 6'(q.tx_div + 6'h01);
         n.tx_tick = (q.tx_div == COAL_LAST);
      end
      if (q.receive_coalesce_config[COAL_SEL_BIT] || (q.rx_s2 && !q.rx_s3)) begin
         n.rx_div  = 6'(q.rx_div + 6'h01);
         n.rx_tick = (q.rx_div == COAL_LAST);
      end

      // One ring checked per cycle keeps the subtractor single
      rl = q.ring_len[q.scan];
      lf = q.last_free[q.scan];
      hw = rx_hw_ptr_in[16*q.scan +: 16];
      free = (lf >= hw) ? 16'(lf - hw) : 16'(lf + rl - hw);
      n.scan = 3'(q.scan + 3'h1);
      n.low[q.scan] = rx_ring_active_in[q.scan] && (free < q.ring_thr[q.scan]);
      if (!q.receive_control[LFC_BIT]) n.low = 8'h00;
      n.flow_req = |n.low;
      n.pause    = n.flow_req && !q.flow_req && link_full_duplex_in;
      n.rx_flow_ctrl_output      = n.flow_req && fifo_mode_in;

      if (rx_valid_in) begin
         pos = rx_sof_in ? 16'h0000 : q.count;
         len = 16'(pos + 16'h0001);
         n.count = len;
         if (rx_sof_in) begin
            n.extr   = '0;
            n.etype  = 16'h0000;
            n.l3_end = L2_HDR_LEN;
         end
         if (pos == ETYPE_HI_POS) n.etype[15:8] = rx_data_in;
         if (pos == ETYPE_LO_POS) n.etype[7:0] = rx_data_in;
         if (pos == L2_HDR_LEN && n.etype == IPV4_TYPE) begin
            n.l3_end = 16'(L2_HDR_LEN + {10'h000, rx_data_in[3:0], 2'b00});
         end
         for (int k = 0; k < 4; k++) begin
            if (eqh_extract_hit(q.receive_byte_extract_config[8*k +: 8], pos, n.l3_end)) n.extr[k] = rx_data_in;
         end
         if (rx_eof_in && q.fstate == FS_IDLE) begin
            n.f_etype = n.etype;
            n.f_len   = len;
            n.f_extr  = n.extr;
            n.result  = 3'b000;
            if (len <= TINY_FRAME_MAX ||
                (len < MIN_FRAME && !q.receive_control[SHORT_ACCEPT_BIT])) begin
               n.result = 3'b010;
            end else if (n.etype == MAC_CTRL_TYPE) begin
               n.result = 3'b100;
            end
            if (n.result != 3'b000) begin
               n.done   = 1'b1;
               n.accept = 1'b0;
            end else if (q.receive_control[FILER_EN_BIT]) begin
               n.fstate     = FS_WALK;
               n.rule       = 4'h0;
               n.skip       = SKIP_NONE;
               n.in_cluster = 1'b0;
            end else begin
               n.done   = 1'b1;
               n.accept = 1'b1;
               n.result = 3'b001;
            end
         end
      end

      case (q.fstate)
         FS_WALK: begin
            c   = rule_ctrl_mem[q.rule];
            hit = eqh_prop(c[3:0], q.f_etype, q.f_len, q.f_extr) == rule_prop_mem[q.rule];
            case (q.skip)
               SKIP_TO_UNCHAINED: if (!c[RULE_CHAIN_BIT]) begin
                  n.skip = SKIP_NONE;
                  if (c[RULE_CLUSTER_BIT]) n.in_cluster = 1'b0;
               end
               SKIP_TO_CLUSTER_END: if (c[RULE_CLUSTER_BIT] && !c[RULE_CHAIN_BIT]) begin
                  n.skip       = SKIP_NONE;
                  n.in_cluster = 1'b0;
               end
               default: case ({c[RULE_CLUSTER_BIT], c[RULE_CHAIN_BIT]})
                  2'b00:   decide = hit;
                  2'b01:   if (!hit) n.skip = SKIP_TO_UNCHAINED;
                  2'b10: begin
                     decide = hit;
                     if (!hit) n.in_cluster = 1'b0;
                  end
                  default: if (hit) n.in_cluster = 1'b1;
                           else n.skip = SKIP_TO_CLUSTER_END;
               endcase
            endcase
            if (decide || q.rule == LAST_RULE) begin
               n.done   = 1'b1;
               n.accept = decide ? !c[RULE_REJECT_BIT] : 1'b1;
               n.result = {2'b00, n.accept};
               n.fstate = FS_IDLE;
            end else begin
               n.rule = 4'(q.rule + 4'h1);
            end
         end
         default: n.fstate = n.fstate;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         q        <= '0;
         q.transmit_coalesce_config   <= REG_RESET;
         q.receive_control  <= REG_RESET;
      end else begin
         q <= n;
      end
   end

   // No reset on the table: software loads every rule first
   always_ff @(posedge core_clk_in) begin
      if (wr_en_in && addr_in == FILER_CTRL_ADDR) rule_ctrl_mem[q.filer_idx] <= wr_data_in[7:0];
      if (wr_en_in && addr_in == FILER_PROP_ADDR) rule_prop_mem[q.filer_idx] <= wr_data_in;
   end
   assign rd_data_out             = q.rdata;
   assign tx_ring_dma_enable_out  = q.dma_en;
   assign tx_coalesce_tick_out    = q.tx_tick;
   assign rx_coalesce_tick_out    = q.rx_tick;
   assign pause_request_out       = q.pause;
   assign rx_flow_ctrl_output_out = q.rx_flow_ctrl_output;
   assign rx_frame_done_out       = q.done;
   assign rx_frame_accept_out     = q.accept;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_halt_on_error;
      (gen_err || tx_no_ready_desc_in) |=> (q.halt & (8'h01 << $past(tx_dma_ring_in))) != 8'h00;
   endproperty
   a_halt_on_error: assert property (p_halt_on_error) else $error("ring not halted");
   property p_halt_cause;
      (q.halt & ~$past(q.halt)) != 8'h00 |-> $past(gen_err || tx_no_ready_desc_in);
   endproperty
   a_halt_cause: assert property (p_halt_cause) else $error("halt set without cause");
   property p_halt_clear;
      (wr_en_in && addr_in == TX_RING_STATUS_ADDR)
         |=> (q.halt & $past(wr_data_in[7:0] & ~halt_set)) == 8'h00;
   endproperty
   a_halt_clear: assert property (p_halt_clear) else $error("halt not cleared");
   property p_dma_off;
      (q.halt != 8'h00) |-> ##1 (q.dma_en & $past(q.halt)) == 8'h00 || $past(q.halt) != q.halt;
   endproperty
   a_dma_off: assert property (p_dma_off) else $error("halted ring dma on");
   property p_frame_evt;
      (tx_frame_sent_in && tx_frame_ring_in == 3'h7) |=> q.frame_evt[2];
   endproperty
   a_frame_evt: assert property (p_frame_evt) else $error("frame event lost");
   property p_ctrl_drop;
      (rx_valid_in && rx_eof_in && q.fstate == FS_IDLE && n.etype == MAC_CTRL_TYPE)
         |=> q.done && !q.accept;
   endproperty
   a_ctrl_drop: assert property (p_ctrl_drop) else $error("control frame kept");
   property p_tiny_drop;
      (rx_valid_in && rx_eof_in && !rx_sof_in && q.fstate == FS_IDLE && q.count < TINY_FRAME_MAX)
         |=> q.done && !q.accept && q.result == 3'b010;
   endproperty
   a_tiny_drop: assert property (p_tiny_drop) else $error("tiny frame kept");
   property p_tx_tick_sys;
      (q.tx_tick && q.transmit_coalesce_config[COAL_SEL_BIT]) ##1 q.transmit_coalesce_config[COAL_SEL_BIT] [*8] |-> ##56 q.tx_tick;
   endproperty
   a_tx_tick_sys: assert property (p_tx_tick_sys) else $error("tick period wrong");
   property p_pause;
      $rose(q.flow_req) && $past(link_full_duplex_in) |-> q.pause ##1 !q.pause;
   endproperty
   a_pause: assert property (p_pause) else $error("pause not one pulse");
   c_halt: cover property (gen_err ##1 q.halt != 8'h00);
   c_filer_reject: cover property (q.fstate == FS_WALK ##[1:16] (q.done && !q.accept));
   c_flow: cover property ($rose(q.rx_flow_ctrl_output));
endmodule : eqh_queue_ctrl

/* File: bench/eqh_peer.sv */
// Link peer model: free-running interface clocks and receive byte stream
`timescale 1ns/100ps
module eqh_peer (
   input  wire logic       core_clk_in,
   output logic            tx_clk_out,
   output logic            rx_clk_out,
   output logic            valid_out,
   output logic            sof_out,
   output logic            eof_out,
   output logic [7:0]      data_out
);
   bit busy = 1'b0;
   initial begin
      {tx_clk_out, rx_clk_out, valid_out, sof_out, eof_out, data_out} = '0;
   end
   // PHY clocks run free; periods of 4 and 6 core cycles, phase kept off core rising edges
   always #80 tx_clk_out = ~tx_clk_out;
   always #120 rx_clk_out = ~rx_clk_out;
   // Idle bus keeps changing so a stale byte is never mistaken for data
   always @(posedge core_clk_in) begin
      if (!busy)
         data_out <= data_out + 8'h5B;
   end
   task automatic send(input int len, input logic [15:0] ety, input logic [7:0] fill);
      busy = 1'b1;
      for (int i = 0; i < len; i++) begin
         @(posedge core_clk_in);
         valid_out <= 1'b1;
         sof_out   <= (i == 0);
         eof_out   <= (i == len - 1);
         data_out  <= (i == 12) ? ety[15:8] : (i == 13) ? ety[7:0] : fill + 8'(i * 37);
      end
      @(posedge core_clk_in);
      {valid_out, sof_out, eof_out} <= 3'b000;
      busy = 1'b0;
   endtask : send
endmodule : eqh_peer

/* File: bench/test_eqh_queue_ctrl.sv */
// Self-checking bench for the queue halt, flow control and filer block
`timescale 1ns/100ps
module test_eqh_queue_ctrl;
   import eqh_pkg::*;
   logic         clk = 1'b0, rst_n = 1'b0, wen = 1'b0, ren = 1'b0, rpend = 1'b0;
   logic [7:0]   addr = '0, act = '0, dma, rd8, fil, b14;
   logic [31:0]  wdat = '0, rdat;
   logic [2:0]   ring = '0, fring = '0;
   logic         bad = 0, unc = 0, rdy = 0, len0 = 0, nordy = 0, sent = 0, fdx = 0, fifo = 0;
   logic [127:0] hwp = '0;
   logic         txc, rxc, txt, rxt, pau, rx_flow_ctrl_output, rv, rs, re, done, acc;
   logic [31:0]  exp_rd[$];
   logic         exp_fr[$];
   int           error_cnt = 0, cmp_count = 0, p1 = 0;
   integer       seed = 73695;
   logic [7:0]   rc [3][3] = '{'{8'h20, 8'h02, 8'h02}, '{8'h80, 8'h22, 8'h02},
                               '{8'hC0, 8'h62, 8'h22}};
   logic [31:0]  rp [3][3] = '{'{32'h0800, 0, 0}, '{32'h0800, 64, 0}, '{32'h0800, 64, 64}};
   int           fl [3] = '{64, 70, 64};
   logic [15:0]  ft [3] = '{16'h0800, 16'h0800, 16'h88B5};
   logic [2:0]   fe [3] = '{3'b100, 3'b110, 3'b010};

   always #20 clk = ~clk;

   eqh_queue_ctrl u_eqh_queue_ctrl (.core_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
      .wr_data_in(wdat), .wr_en_in(wen), .rd_en_in(ren), .rd_data_out(rdat),
      .tx_dma_ring_in(ring), .tx_bad_addr_in(bad), .tx_read_uncorrectable_in(unc),
      .tx_desc_ready_in(rdy), .tx_desc_len_zero_in(len0), .tx_no_ready_desc_in(nordy),
      .tx_frame_sent_in(sent), .tx_frame_ring_in(fring), .tx_ring_dma_enable_out(dma),
      .tx_interface_clock_in(txc), .rx_interface_clock_in(rxc), .tx_coalesce_tick_out(txt),
      .rx_coalesce_tick_out(rxt), .rx_ring_active_in(act), .rx_hw_ptr_in(hwp),
      .link_full_duplex_in(fdx), .fifo_mode_in(fifo), .pause_request_out(pau),
      .rx_flow_ctrl_output_out(rx_flow_ctrl_output), .rx_valid_in(rv), .rx_sof_in(rs), .rx_eof_in(re),
      .rx_data_in(rd8), .rx_frame_done_out(done), .rx_frame_accept_out(acc));
   eqh_peer u_eqh_peer (.core_clk_in(clk), .tx_clk_out(txc), .rx_clk_out(rxc),
      .valid_out(rv), .sof_out(rs), .eof_out(re), .data_out(rd8));

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic summarize;
      check(32'(exp_rd.size() + exp_fr.size()), 0);
      $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   // Results are compared in the cycle they stand
   always @(posedge clk) begin
      if (rpend)
         check(rdat, exp_rd.pop_front());
      if (rst_n && done !== 1'b0)
         check(32'(acc), 32'(exp_fr.pop_front()));
      rpend <= ren;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wen  <= 1'b1;
      @(posedge clk);
      wen <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      @(posedge clk);
      addr <= a;
      ren  <= 1'b1;
      @(posedge clk);
      ren <= 1'b0;
   endtask : rd
   task automatic ev(input int k, input logic [2:0] r);
      @(posedge clk);
      ring <= r;
      case (k)
         0: bad <= 1'b1;
         1: unc <= 1'b1;
         2: {rdy, len0} <= 2'b11;
         3: nordy <= 1'b1;
         4: rdy <= 1'b1;
         default: {sent, fring} <= {1'b1, r};
      endcase
      @(posedge clk);
      {bad, unc, rdy, len0, nordy, sent} <= '0;
   endtask : ev
   // Longest filer walk is 16 cycles, so 20 always covers the decision
   task automatic frame(input int n, input logic [15:0] t, input logic a);
      exp_fr.push_back(a);
      fil = 8'($random(seed));
      u_eqh_peer.send(n, t, fil);
      repeat (20) @(posedge clk);
   endtask : frame
   task automatic gap(input bit rx, input int want);
      int n;
      n = 0;
      while (!(rx ? rxt : txt) && n < 1000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      n = 1;
      while (!(rx ? rxt : txt) && n < 1000) begin
         @(posedge clk);
         n++;
      end
      check(n, want);
   endtask : gap
   task automatic rule(input int i, input logic [7:0] c, input logic [31:0] p);
      wr(FILER_INDEX_ADDR, 32'(i));
      wr(FILER_CTRL_ADDR, 32'(c));
      wr(FILER_PROP_ADDR, p);
   endtask : rule

   initial begin
      #(40 * 20000);
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rd(TX_RING_STATUS_ADDR, REG_RESET);
      rd(RX_CTRL_ADDR, REG_RESET);
      rd(8'hFC, REG_RESET);
      wr(TX_QUEUE_EN_ADDR, 32'h0F);
      ev(4, 3'd7);
      rd(TX_RING_STATUS_ADDR, REG_RESET);
      for (int k = 0; k < 8; k++) begin
         ev(k % 4, 3'(k));
         rd(TX_RING_STATUS_ADDR, 32'((2 << k) - 1));
      end
      check(32'(dma), 32'h0);
      for (int k = 0; k < 8; k++)
         ev(5, 3'(k));
      rd(TX_RING_STATUS_ADDR, 32'h00E0_00FF);
      wr(TX_QUEUE_EN_ADDR, 32'hFF);
      wr(TX_RING_STATUS_ADDR, 32'h0000_00F0);
      rd(TX_RING_STATUS_ADDR, 32'h00E0_000F);
      check(32'(dma), 32'hF0);
      wr(TX_COAL_ADDR, 32'h2);
      gap(0, 64);
      wr(TX_COAL_ADDR, 32'h0);
      gap(0, 256);
      gap(1, 384);
      wr(RX_COAL_ADDR, 32'h2);
      rd(RX_COAL_ADDR, 32'h2);
      gap(1, 64);
      hwp <= {$random(seed), $random(seed), $random(seed), 16'($random(seed)), 16'h0000};
      act <= 8'h01;
      {fdx, fifo} <= 2'b11;
      wr(RING_SEL_ADDR, 32'h0);
      wr(RING_PARAMS_ADDR, 32'h0004_0010);
      wr(RING_LAST_FREE_ADDR, 32'h2);
      check(32'(rx_flow_ctrl_output), 32'h0);
      wr(RX_CTRL_ADDR, 32'h0002_0000);
      for (int i = 0; i < 30 && pau !== 1'b1; i++) @(posedge clk);
      check(32'(pau), 32'h1);
      check(32'(rx_flow_ctrl_output), 32'h1);
      wr(RING_LAST_FREE_ADDR, 32'hA);
      repeat (20) @(posedge clk);
      check(32'(rx_flow_ctrl_output), 32'h0);
      wr(RX_CTRL_ADDR, 32'h0);
      frame(16, 16'h0800, 1'b0);
      frame(17, 16'h0800, 1'b0);
      wr(RX_CTRL_ADDR, 32'h10);
      frame(16, 16'h0800, 1'b0);
      frame(17, 16'h0800, 1'b1);
      frame(64, MAC_CTRL_TYPE, 1'b0);
      rd(RX_RESULT_ADDR, 32'h4);
      // Leave FIFO mode so layer-2 extraction is legal without the parser
      fifo <= 1'b0;
      wr(RX_EXTRACT_ADDR, 32'hBF48_C280);
      frame(64, IPV4_TYPE, 1'b1);
      b14 = 8'(fil + 8'h06);
      p1  = 16 + 4 * int'(b14[3:0]);
      rd(RX_EXTRACTED_ADDR, {8'h00, 8'(fil + 8'h28),
         (p1 < 64) ? 8'(fil + 8'(p1 * 37)) : 8'h00, b14});
      for (int i = 0; i < 16; i++)
         rule(i, 8'h02, 32'h0);
      wr(RX_CTRL_ADDR, 32'h8000);
      for (int c = 0; c < 3; c++) begin
         for (int r = 0; r < 3; r++)
            rule(r, rc[c][r], rp[c][r]);
         for (int j = 0; j < 3; j++)
            frame(fl[j], ft[j], fe[c][j]);
      end
      repeat (3) @(posedge clk);
      summarize();
   end
endmodule : test_eqh_queue_ctrl
